// file: hdl/pdm_pkg.sv
// Purpose: shared constants and types of the process-data image mapper
// Assumes: 32-bit words, 16-bit object indices, 8-bit subindices
// Notes:   master register map is byte addressed, one word per register
package pdm_pkg;

  // widths and sizes
  localparam int PDM_WORD_W = 32;
  localparam int PDM_IDX_W = 16;
  localparam int PDM_SUB_W = 8;
  localparam int PDM_MEAS_N = 54;

  // object directory indices
  localparam logic [15:0] PDM_OBJ_MAP = 16'h1A00;
  localparam logic [15:0] PDM_OBJ_ENABLE = 16'h21B0;
  localparam logic [15:0] PDM_OBJ_ASSIGN = 16'h1C13;
  localparam logic [15:0] PDM_OBJ_MEAS = 16'h6065;
  localparam logic [7:0] PDM_MEAS_LEN = 8'h20;
  localparam logic [7:0] PDM_ASSIGN_CNT = 8'h01;
  localparam logic [7:0] PDM_SUB_ONE = 8'h01;
  localparam logic [7:0] PDM_SUB_TWO = 8'h02;

  // values after reset
  localparam logic PDM_EN_RST = 1'b1;

  // master register byte offsets
  localparam logic [7:0] PDM_REG_CTRL = 8'h00;
  localparam logic [7:0] PDM_REG_SDO_ADDR = 8'h04;
  localparam logic [7:0] PDM_REG_SDO_WDATA = 8'h08;
  localparam logic [7:0] PDM_REG_SDO_GO = 8'h0C;
  localparam logic [7:0] PDM_REG_STATUS = 8'h10;
  localparam logic [7:0] PDM_REG_SDO_RDATA = 8'h14;
  localparam logic [7:0] PDM_REG_PD_COUNT = 8'h18;
  localparam logic [7:0] PDM_REG_PD_SEL = 8'h1C;
  localparam logic [7:0] PDM_REG_PD_DATA = 8'h20;

  // field positions
  localparam int PDM_CTRL_CYC_BIT = 8;
  localparam int PDM_ST_BUSY_BIT = 0;
  localparam int PDM_ST_ERR_BIT = 1;
  localparam int PDM_ST_STALE_BIT = 2;
  localparam int PDM_ST_PD_BIT = 3;

  // bus responses
  localparam logic [1:0] PDM_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDM_RESP_SLVERR = 2'h2;

  // slave states and service operations
  typedef enum logic [1:0] {AL_INIT, AL_PREOP, AL_SAFEOP, AL_OP} pdm_al_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LIST, OP_DESC} pdm_op_t;

  // one mapping entry: index, subindex, length in bits
  function automatic logic [31:0] pdm_map_entry(input logic [7:0] sub);
    return {PDM_OBJ_MEAS, sub, PDM_MEAS_LEN};
  endfunction

  // byte-lane merge of a bus write
  function automatic logic [31:0] pdm_apply_strb(input logic [31:0] old,
                                                 input logic [31:0] nw,
                                                 input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// file: hdl/pdm_link_if.sv
// Purpose: link between fieldbus master end and sensor device end
// Assumes: both ends on ref_clk
// Notes:   each signal has exactly one driving end
`timescale 1ns/1ps
interface pdm_link_if #(
  parameter int MEAS_N = pdm_pkg::PDM_MEAS_N
) ();
  import pdm_pkg::*;
  localparam int CNT_W = $clog2(MEAS_N + 1);

  // master to device
  pdm_al_t al_state;
  logic cycle_strobe;
  logic sdo_req_valid;
  pdm_op_t sdo_op;
  logic [PDM_IDX_W-1:0] sdo_index;
  logic [PDM_SUB_W-1:0] sdo_sub;
  logic [PDM_WORD_W-1:0] sdo_wdata;
  // device to master
  logic sdo_rsp_valid;
  logic sdo_rsp_err;
  logic [PDM_WORD_W-1:0] sdo_rdata;
  logic input_sync_channel_valid;
  logic [CNT_W-1:0] input_sync_channel_count;
  logic [PDM_WORD_W-1:0] input_sync_channel_img [0:MEAS_N-1];

  modport device (
    input al_state, cycle_strobe, sdo_req_valid, sdo_op, sdo_index,
    input sdo_sub, sdo_wdata,
    output sdo_rsp_valid, sdo_rsp_err, sdo_rdata,
    output input_sync_channel_valid, input_sync_channel_count,
    output input_sync_channel_img
  );

  modport master (
    output al_state, cycle_strobe, sdo_req_valid, sdo_op, sdo_index,
    output sdo_sub, sdo_wdata,
    input sdo_rsp_valid, sdo_rsp_err, sdo_rdata,
    input input_sync_channel_valid, input_sync_channel_count,
    input input_sync_channel_img
  );
endinterface

// file: hdl/pdm_device.sv
// Purpose: sensor end; keeps measurement enables, derives the mapping
//          table and packs the cyclic transmit image
// Assumes: meas_in words are stable in the cycle of cycle_strobe
// Notes:   rebuild of the mapping takes MEAS_N cycles; service
//          requests wait meanwhile
`timescale 1ns/1ps
// Function
// - measurements leave only in the cyclic image
// - parameters travel only over the service channel
// - exactly one transmit image towards master
// - no output image from master consumed
// - counter and timestamp words are 32 bits
// - full measurement set selectable by enables
// - two statistics sets, min max peak-peak
// - diameter A first rising, B last falling
// - gap A first falling, B next rising
// - image carried on input sync channel
// - enable changes accepted only in preop
// - mapping derived from enables, never written
// - master reloads directory after enable change
// - map subindex zero gives entry count
// - subindices one to count describe entries
// - entry is index, subindex, bit length
// - mapping values held as plain hex numbers
// - service channel reads and writes objects
// - directory list and object description served
// - accesses resolved by index plus subindex; list requests use the subindex alone, descriptions the index alone
// - object indices are 16 bits wide
// - image flows in safeop and op only
module pdm_device
  import pdm_pkg::*;
#(
  parameter int MEAS_N = PDM_MEAS_N
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link to the master
  pdm_link_if.device lnk,
  // measurement words from the sensor core, in enable order
  // edge slots fixed by order
  input wire logic [PDM_WORD_W-1:0] meas_in [0:MEAS_N-1],
  // mapping status towards the sensor core
  output logic [$clog2(MEAS_N+1)-1:0] map_count,
  output logic map_busy
);

  localparam int CNT_W = $clog2(MEAS_N + 1);
  localparam int SEL_W = $clog2(MEAS_N);
  localparam logic [PDM_SUB_W-1:0] N_SUB = PDM_SUB_W'(MEAS_N);
  localparam logic [SEL_W-1:0] LAST_SEL = SEL_W'(MEAS_N - 1);

  typedef enum logic {ST_IDLE, ST_BUILD} pdm_dev_st_t;

  logic [MEAS_N-1:0] en_r;
  logic [SEL_W-1:0] sel_r [0:MEAS_N-1];
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] bld_cnt_r;
  logic [SEL_W-1:0] bld_pos_r;
  pdm_dev_st_t st_r;
  logic take;
  logic wr_ok;
  logic wr_hit;
  logic pd_run;
  logic sub_in_map;
  logic sub_in_en;
  logic [PDM_SUB_W-1:0] sub_m1;
  logic [PDM_WORD_W-1:0] rd_data;
  logic rd_err;

  // a request is taken only while idle and no answer is showing
  assign take = lnk.sdo_req_valid && !lnk.sdo_rsp_valid &&
                (st_r == ST_IDLE);
  assign sub_m1 = lnk.sdo_sub - PDM_SUB_ONE;
  assign sub_in_map = (lnk.sdo_sub != '0) &&
                      (lnk.sdo_sub <= PDM_SUB_W'(cnt_r));
  assign sub_in_en = (lnk.sdo_sub != '0) && (lnk.sdo_sub <= N_SUB);

  assign wr_ok = (lnk.sdo_index == PDM_OBJ_ENABLE) && sub_in_en &&
                 (lnk.al_state == AL_PREOP);
  assign wr_hit = take && (lnk.sdo_op == OP_WRITE) && wr_ok;

  assign pd_run = ((lnk.al_state == AL_SAFEOP) ||
                   (lnk.al_state == AL_OP)) && (st_r == ST_IDLE);

  // status outputs come straight from the mapping registers
  assign map_count = cnt_r;
  assign map_busy = (st_r == ST_BUILD);

  // service decode; reads and writes find an object by index and subindex, a list entry by subindex alone, a description by index alone
  always_comb begin
    rd_data = '0;
    rd_err = 1'b1;
    case (lnk.sdo_op)
      OP_READ: begin
        case (lnk.sdo_index)
          PDM_OBJ_MAP: begin
            if (lnk.sdo_sub == '0) begin
              rd_data = PDM_WORD_W'(cnt_r);
              rd_err = 1'b0;
            end else if (sub_in_map) begin
              rd_data = pdm_map_entry(
                PDM_SUB_W'(sel_r[sub_m1[SEL_W-1:0]]) + PDM_SUB_ONE);
              rd_err = 1'b0;
            end
          end
          PDM_OBJ_ENABLE: begin
            if (lnk.sdo_sub == '0) begin
              rd_data = PDM_WORD_W'(N_SUB);
              rd_err = 1'b0;
            end else if (sub_in_en) begin
              rd_data = PDM_WORD_W'(en_r[sub_m1[SEL_W-1:0]]);
              rd_err = 1'b0;
            end
          end
          PDM_OBJ_ASSIGN: begin
            if (lnk.sdo_sub == '0) begin
              rd_data = PDM_WORD_W'(PDM_ASSIGN_CNT);
              rd_err = 1'b0;
            end else if (lnk.sdo_sub == PDM_SUB_ONE) begin
              rd_data = PDM_WORD_W'(PDM_OBJ_MAP);
              rd_err = 1'b0;
            end
          end
          default: begin
            rd_err = 1'b1;
          end
        endcase
      end
      OP_WRITE: begin
        rd_err = !wr_ok;
      end
      OP_LIST: begin
        rd_err = 1'b0;
        if (lnk.sdo_sub == '0) begin
          rd_data = PDM_WORD_W'(PDM_OBJ_MAP);
        end else if (lnk.sdo_sub == PDM_SUB_ONE) begin
          rd_data = PDM_WORD_W'(PDM_OBJ_ASSIGN);
        end else if (lnk.sdo_sub == PDM_SUB_TWO) begin
          rd_data = PDM_WORD_W'(PDM_OBJ_ENABLE);
        end else begin
          rd_err = 1'b1;
        end
      end
      OP_DESC: begin
        rd_err = 1'b0;
        case (lnk.sdo_index)
          PDM_OBJ_MAP: rd_data = PDM_WORD_W'(cnt_r);
          PDM_OBJ_ASSIGN: rd_data = PDM_WORD_W'(PDM_ASSIGN_CNT);
          PDM_OBJ_ENABLE: rd_data = PDM_WORD_W'(N_SUB);
          default: rd_err = 1'b1;
        endcase
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // service answer, one cycle after the request is taken
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk.sdo_rsp_valid <= 1'b0;
      lnk.sdo_rsp_err <= 1'b0;
      lnk.sdo_rdata <= '0;
    end else begin
      lnk.sdo_rsp_valid <= take;
      if (take) begin
        lnk.sdo_rdata <= rd_data;
        lnk.sdo_rsp_err <= rd_err;
      end
    end
  end

  // measurement enables; all on after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r <= {MEAS_N{PDM_EN_RST}};
    end else if (wr_hit) begin
      en_r[sub_m1[SEL_W-1:0]] <= lnk.sdo_wdata[0];
    end
  end

  // mapping rebuild walk; starts at reset and after each enable write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_BUILD;
      bld_pos_r <= '0;
      bld_cnt_r <= '0;
      cnt_r <= '0;
    end else if (wr_hit) begin
      st_r <= ST_BUILD;
      bld_pos_r <= '0;
      bld_cnt_r <= '0;
    end else if (st_r == ST_BUILD) begin
      if (en_r[bld_pos_r]) begin
        bld_cnt_r <= bld_cnt_r + CNT_W'(1);
      end
      bld_pos_r <= bld_pos_r + SEL_W'(1);
      if (bld_pos_r == LAST_SEL) begin
        cnt_r <= bld_cnt_r + CNT_W'(en_r[bld_pos_r]);
        st_r <= ST_IDLE;
      end
    end
  end

  // entry order list
  // selection table is pure data, so it carries no reset
  always_ff @(posedge ref_clk) begin
    if ((st_r == ST_BUILD) && en_r[bld_pos_r]) begin
      sel_r[bld_cnt_r[SEL_W-1:0]] <= bld_pos_r;
    end
  end

  // cyclic image; there is no path for master output data
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk.input_sync_channel_valid <= 1'b0;
      lnk.input_sync_channel_count <= '0;
      for (int k = 0; k < MEAS_N; k++) begin
        lnk.input_sync_channel_img[k] <= '0;
      end
    end else begin
      lnk.input_sync_channel_valid <= lnk.cycle_strobe && pd_run;
      if (lnk.cycle_strobe && pd_run) begin
        lnk.input_sync_channel_count <= cnt_r;
        for (int k = 0; k < MEAS_N; k++) begin
          lnk.input_sync_channel_img[k] <= (CNT_W'(k) < cnt_r) ?
                                           meas_in[sel_r[k]] : '0;
        end
      end
    end
  end

endmodule // pdm_device

// file: hdl/pdm_master.sv
// Purpose: fieldbus master end; software drives it over AXI4-Lite
// Assumes: software sets the slave state and triggers cycles
// Notes:   one service request in flight; a new go while busy is
//          ignored and only shows as the busy bit
`timescale 1ns/1ps
module pdm_master
  import pdm_pkg::*;
#(
  parameter int MEAS_N = PDM_MEAS_N,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // link to the device
  pdm_link_if.master lnk
);

  localparam int CNT_W = $clog2(MEAS_N + 1);
  localparam int SEL_W = $clog2(MEAS_N);

  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [31:0] sdo_addr_r;
  logic [31:0] sdo_wr_r;
  logic [31:0] sdo_rd_r;
  logic [SEL_W-1:0] pd_sel_r;
  logic [CNT_W-1:0] pd_cnt_r;
  logic [31:0] pd_img_r [0:MEAS_N-1];
  logic err_r;
  logic stale_r;
  logic pd_new_r;
  logic do_wr;
  logic wr_known;
  logic go;
  logic blocked;
  logic rd_known;
  logic [31:0] rd_mux;

  // write decode once both address and data are held
  assign do_wr = aw_got_r && w_got_r && !bvalid;
  assign wr_known = (aw_addr_r == PDM_REG_CTRL) ||
                    (aw_addr_r == PDM_REG_SDO_ADDR) ||
                    (aw_addr_r == PDM_REG_SDO_WDATA) ||
                    (aw_addr_r == PDM_REG_SDO_GO) ||
                    (aw_addr_r == PDM_REG_STATUS) ||
                    (aw_addr_r == PDM_REG_PD_SEL);
  assign go = do_wr && (aw_addr_r == PDM_REG_SDO_GO) && !lnk.sdo_req_valid;
  assign blocked = (pdm_op_t'(sdo_addr_r[1:0]) == OP_WRITE) &&
                   (sdo_addr_r[31:16] == PDM_OBJ_ENABLE) &&
                   (lnk.al_state != AL_PREOP);

  // write channels: address and data taken in either order
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= PDM_RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= 8'(awaddr);
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready <= 1'b0;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_known ? PDM_RESP_OKAY : PDM_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // software registers, slave state and cycle trigger
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk.al_state <= AL_INIT;
      lnk.cycle_strobe <= 1'b0;
      sdo_addr_r <= '0;
      sdo_wr_r <= '0;
      pd_sel_r <= '0;
    end else begin
      lnk.cycle_strobe <= do_wr && (aw_addr_r == PDM_REG_CTRL) &&
                          w_strb_r[1] && w_data_r[PDM_CTRL_CYC_BIT];
      if (do_wr) begin
        case (aw_addr_r)
          PDM_REG_CTRL: if (w_strb_r[0]) begin
            lnk.al_state <= pdm_al_t'(w_data_r[1:0]);
          end
          PDM_REG_SDO_ADDR: begin
            sdo_addr_r <= pdm_apply_strb(sdo_addr_r, w_data_r, w_strb_r);
          end
          PDM_REG_SDO_WDATA: begin
            sdo_wr_r <= pdm_apply_strb(sdo_wr_r, w_data_r, w_strb_r);
          end
          PDM_REG_PD_SEL: if (w_strb_r[0]) begin
            pd_sel_r <= w_data_r[SEL_W-1:0];
          end
          default: ;
        endcase
      end
    end
  end

  // service request, held until the device answers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk.sdo_req_valid <= 1'b0;
      lnk.sdo_op <= OP_READ;
      lnk.sdo_index <= '0;
      lnk.sdo_sub <= '0;
      lnk.sdo_wdata <= '0;
      sdo_rd_r <= '0;
      err_r <= 1'b0;
      stale_r <= 1'b0;
    end else begin
      if (go && blocked) begin
        err_r <= 1'b1;
      end else if (go) begin
        lnk.sdo_req_valid <= 1'b1;
        lnk.sdo_op <= pdm_op_t'(sdo_addr_r[1:0]);
        lnk.sdo_index <= sdo_addr_r[31:16];
        lnk.sdo_sub <= sdo_addr_r[15:8];
        lnk.sdo_wdata <= sdo_wr_r;
        err_r <= 1'b0;
      end
      if (lnk.sdo_rsp_valid) begin
        lnk.sdo_req_valid <= 1'b0;
        sdo_rd_r <= lnk.sdo_rdata;
        err_r <= lnk.sdo_rsp_err;
        if (!lnk.sdo_rsp_err && (lnk.sdo_op == OP_WRITE) &&
            (lnk.sdo_index == PDM_OBJ_ENABLE)) begin
          stale_r <= 1'b1;
        end else if (!lnk.sdo_rsp_err && (lnk.sdo_op == OP_READ) &&
                     (lnk.sdo_index == PDM_OBJ_MAP) &&
                     (lnk.sdo_sub == '0)) begin
          stale_r <= 1'b0;
        end
      end
    end
  end

  // image copy; a new image wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_new_r <= 1'b0;
      pd_cnt_r <= '0;
      for (int k = 0; k < MEAS_N; k++) begin
        pd_img_r[k] <= '0;
      end
    end else if (lnk.input_sync_channel_valid) begin
      pd_new_r <= 1'b1;
      pd_cnt_r <= lnk.input_sync_channel_count;
      for (int k = 0; k < MEAS_N; k++) begin
        pd_img_r[k] <= lnk.input_sync_channel_img[k];
      end
    end else if (do_wr && (aw_addr_r == PDM_REG_STATUS) && w_strb_r[0] &&
                 w_data_r[PDM_ST_PD_BIT]) begin
      pd_new_r <= 1'b0;
    end
  end

  // read decode
  always_comb begin
    rd_mux = '0;
    rd_known = 1'b1;
    case (8'(araddr))
      PDM_REG_CTRL: rd_mux[1:0] = lnk.al_state;
      PDM_REG_SDO_ADDR: rd_mux = sdo_addr_r;
      PDM_REG_SDO_WDATA: rd_mux = sdo_wr_r;
      PDM_REG_STATUS: begin
        rd_mux[PDM_ST_BUSY_BIT] = lnk.sdo_req_valid;
        rd_mux[PDM_ST_ERR_BIT] = err_r;
        rd_mux[PDM_ST_STALE_BIT] = stale_r;
        rd_mux[PDM_ST_PD_BIT] = pd_new_r;
      end
      PDM_REG_SDO_RDATA: rd_mux = sdo_rd_r;
      PDM_REG_PD_COUNT: rd_mux = 32'(pd_cnt_r);
      PDM_REG_PD_SEL: rd_mux = 32'(pd_sel_r);
      PDM_REG_PD_DATA: begin
        if ({1'b0, pd_sel_r} < (SEL_W+1)'(MEAS_N)) begin
          rd_mux = pd_img_r[pd_sel_r];
        end
      end
      default: rd_known = 1'b0;
    endcase
  end

  // read channels, answer one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= PDM_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_known ? PDM_RESP_OKAY : PDM_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule // pdm_master

// file: sim/pdm_assertions.sv
// Purpose: link checks between master end and device end
// Assumes: one clock, reset_n active low
// Notes:   image words unwatched; the count stands in for them
`timescale 1ns/1ps
module pdm_assertions
  import pdm_pkg::*;
#(
  parameter int MEAS_N = PDM_MEAS_N
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // master to device
  input wire pdm_al_t al_state,
  input wire logic cycle_strobe,
  input wire logic sdo_req_valid,
  input wire pdm_op_t sdo_op,
  input wire logic [15:0] sdo_index,
  // device to master
  input wire logic sdo_rsp_valid,
  input wire logic sdo_rsp_err,
  input wire logic input_sync_channel_valid,
  input wire logic [$clog2(MEAS_N+1)-1:0] input_sync_channel_count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // an image needs a strobe taken in a running state
  property p_pd_state;
    input_sync_channel_valid |-> $past(cycle_strobe) &&
      $past(al_state) inside {AL_SAFEOP, AL_OP};
  endproperty
  a_pd_state: assert property (p_pd_state)
    else $error("image without strobe in run state");
  property p_pd_idle;
    cycle_strobe && al_state inside {AL_INIT, AL_PREOP}
      |=> !input_sync_channel_valid;
  endproperty
  a_pd_idle: assert property (p_pd_idle)
    else $error("image sent outside run state");
  // count only moves with a whole new image
  property p_cnt_hold;
    !input_sync_channel_valid |-> $stable(input_sync_channel_count);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("image count changed between images");
  property p_rsp_cause;
    sdo_rsp_valid |-> sdo_req_valid && $past(sdo_req_valid);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause)
    else $error("answer without request");
  property p_rsp_pulse;
    sdo_rsp_valid |=> !sdo_rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("answer longer than one cycle");
  // a rebuild may delay the answer by the table length
  property p_rsp_bound;
    sdo_req_valid && !sdo_rsp_valid |-> ##[1:60] sdo_rsp_valid;
  endproperty
  a_rsp_bound: assert property (p_rsp_bound)
    else $error("request not answered in time");
  property p_map_ro;
    sdo_rsp_valid && sdo_op == OP_WRITE && sdo_index == PDM_OBJ_MAP
      |-> sdo_rsp_err;
  endproperty
  a_map_ro: assert property (p_map_ro)
    else $error("mapping table write accepted");
  property p_wr_preop;
    sdo_rsp_valid && sdo_op == OP_WRITE && al_state != AL_PREOP
      |-> sdo_rsp_err;
  endproperty
  a_wr_preop: assert property (p_wr_preop)
    else $error("write accepted outside preop");

  // main scenarios
  c_pd: cover property (input_sync_channel_valid);
  c_err: cover property (sdo_rsp_valid && sdo_rsp_err);
  c_ok: cover property (sdo_rsp_valid && !sdo_rsp_err);
endmodule // pdm_assertions

// file: sim/process_data_image_mapper_tb_top.sv
// Purpose: software on AXI4-Lite down to the cyclic image
// Assumes: MEAS_N 54, enables all on after reset
// Notes:   state starts in init, so enable writes are refused first
`timescale 1ns/1ps
module process_data_image_mapper_tb_top;
  import pdm_pkg::*;
  localparam int N = 54;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rdata, rd, st;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, map_busy;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] map_count;
  logic [31:0] meas_in [0:N-1];
  logic [31:0] lst [0:2] = '{32'h1A00, 32'h1C13, 32'h21B0};
  int n_mismatch = 0, samples_checked = 0;

  pdm_link_if #(.MEAS_N(N)) lnk ();
  pdm_master #(.MEAS_N(N)) i_pdm_master (.ref_clk, .reset_n,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .lnk(lnk));
  pdm_device #(.MEAS_N(N)) i_pdm_device (.ref_clk, .reset_n,
    .lnk(lnk), .meas_in, .map_count, .map_busy);
  pdm_assertions #(.MEAS_N(N)) i_pdm_assertions (.ref_clk, .reset_n,
    .al_state(lnk.al_state), .cycle_strobe(lnk.cycle_strobe),
    .sdo_req_valid(lnk.sdo_req_valid), .sdo_op(lnk.sdo_op),
    .sdo_index(lnk.sdo_index), .sdo_rsp_valid(lnk.sdo_rsp_valid),
    .sdo_rsp_err(lnk.sdo_rsp_err),
    .input_sync_channel_valid(lnk.input_sync_channel_valid),
    .input_sync_channel_count(lnk.input_sync_channel_count));

  // free running clock
  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // write: both channels offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // one service request; busy polled so no latency is assumed
  task automatic sc(input pdm_op_t op, input logic [15:0] ix,
      input logic [7:0] sb, input logic [31:0] d, input logic [31:0] x,
      input logic e);
    wr(PDM_REG_SDO_ADDR, {ix, sb, 6'h00, op});
    wr(PDM_REG_SDO_WDATA, d);
    wr(PDM_REG_SDO_GO, 32'h0);
    do rd_reg(PDM_REG_STATUS); while (rd[PDM_ST_BUSY_BIT] !== 1'b0);
    st = rd;
    rd_reg(PDM_REG_SDO_RDATA);
    chk(32'(st[PDM_ST_ERR_BIT]), 32'(e));
    if (!e && op != OP_WRITE) chk(rd, x);
  endtask

  task automatic pd(input logic [31:0] k, input logic [31:0] x);
    wr(PDM_REG_PD_SEL, k);
    rd_reg(PDM_REG_PD_DATA);
    chk(rd, x);
  endtask

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // cut a hang short
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end

  // main sequence
  initial begin
    for (int k = 0; k < N; k++) meas_in[k] <= 32'hA500_0000 + k;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    sc(OP_READ, PDM_OBJ_MAP, 8'h00, 32'h0, 32'h36, 1'b0);
    sc(OP_READ, PDM_OBJ_MAP, 8'h01, 32'h0, 32'h6065_0120, 1'b0);
    sc(OP_READ, PDM_OBJ_MAP, 8'h36, 32'h0, 32'h6065_3620, 1'b0);
    sc(OP_READ, PDM_OBJ_MAP, 8'h37, 32'h0, 32'h0, 1'b1);
    sc(OP_READ, PDM_OBJ_ASSIGN, 8'h01, 32'h0, 32'h1A00, 1'b0);
    sc(OP_READ, PDM_OBJ_MEAS, 8'h01, 32'h0, 32'h0, 1'b1);
    sc(OP_WRITE, PDM_OBJ_MAP, 8'h01, 32'h0, 32'h0, 1'b1);
    sc(OP_WRITE, PDM_OBJ_ENABLE, 8'h01, 32'h0, 32'h0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      sc(OP_LIST, 16'h0, 8'(k), 32'h0, lst[k], 1'b0);
    end
    sc(OP_LIST, 16'h0, 8'h03, 32'h0, 32'h0, 1'b1);
    sc(OP_DESC, PDM_OBJ_ENABLE, 8'h00, 32'h0, 32'h36, 1'b0);
    // preop: strobe ignored, enable write taken
    wr(PDM_REG_CTRL, 32'h0000_0101);
    rd_reg(PDM_REG_STATUS);
    chk(32'(rd[PDM_ST_PD_BIT]), 32'h0);
    sc(OP_WRITE, PDM_OBJ_ENABLE, 8'h01, 32'h0, 32'h0, 1'b0);
    chk(32'(st[PDM_ST_STALE_BIT]), 32'h1);
    // rebuild walks the whole table, so it is still going here
    chk(32'(map_busy), 32'h1);
    sc(OP_READ, PDM_OBJ_MAP, 8'h00, 32'h0, 32'h35, 1'b0);
    chk(32'(map_count), 32'h35);
    chk(32'(map_busy), 32'h0);
    sc(OP_READ, PDM_OBJ_MAP, 8'h01, 32'h0, 32'h6065_0220, 1'b0);
    sc(OP_DESC, PDM_OBJ_MAP, 8'h00, 32'h0, 32'h35, 1'b0);
    sc(OP_READ, PDM_OBJ_ENABLE, 8'h01, 32'h0, 32'h0, 1'b0);
    sc(OP_READ, PDM_OBJ_ENABLE, 8'h02, 32'h0, 32'h1, 1'b0);
    // safeop cycle packs the remaining measurements
    wr(PDM_REG_CTRL, 32'h0000_0102);
    rd_reg(PDM_REG_STATUS);
    chk(32'(rd[PDM_ST_PD_BIT]), 32'h1);
    rd_reg(PDM_REG_PD_COUNT);
    chk(rd, 32'h35);
    pd(32'h0, 32'hA500_0001);
    pd(32'h34, 32'hA500_0035);
    pd(32'h35, 32'h0);
    sc(OP_WRITE, PDM_OBJ_ENABLE, 8'h02, 32'h0, 32'h0, 1'b1);
    @(posedge ref_clk);
    meas_in[1] <= 32'hFFFF_FFFF;
    wr(PDM_REG_CTRL, 32'h0000_0103);
    pd(32'h0, 32'hFFFF_FFFF);
    // unmapped register
    wr(8'hF0, 32'h0);
    chk(32'(rs), 32'(PDM_RESP_SLVERR));
    rd_reg(8'hF0);
    chk(32'(rs), 32'(PDM_RESP_SLVERR));
    end_sim();
  end
endmodule // process_data_image_mapper_tb_top
